// >>> src/cpc_cfg.svh
// Offsets, field positions, reset values and timing constants of the pickup conditioning control
`ifndef CPC_CFG_SVH
`define CPC_CFG_SVH
`define CPC_ADDR_RUN_CFG     4'h0
`define CPC_ADDR_CRANK_CTRL  4'h1
`define CPC_ADDR_MISC_CFG    4'h2
`define CPC_ADDR_STATUS      4'h3
`define CPC_ADDR_CMD         4'h4
`define CPC_RST_RUN_CFG      8'h50
`define CPC_RST_CRANK_CTRL   8'h00
`define CPC_RST_MISC_CFG     8'h00
`define CPC_MISC_AUTO_BIT    7
`define CPC_MISC_HILO_BIT    2
`define CPC_MISC_DISABLE_BIT 1
`define CPC_MISC_DEGL_BIT    3
`define CPC_STAT_PEAK_LSB    4
`define CPC_STAT_CLH_BIT     1
`define CPC_STAT_CLL_BIT     0
`define CPC_CMD_RESET_BIT    0
`define CPC_PEAK_RST         4'h0
`define CPC_DEGL_SHIFT       7
`define CPC_BLANK_SHIFT      5
`endif

// >>> src/cpc_pkg.sv
// Types shared by the pickup conditioning control
package cpc_pkg;
    typedef struct packed {
        logic [3:0] thresh;
        logic [3:0] blank;
    } cpc_sel_t;
    typedef struct packed {
        logic       valid;
        logic [3:0] code;
    } cpc_peak_t;
    typedef enum logic [2:0] {
        CPC_IDLE = 3'b001,
        CPC_REF  = 3'b010,
        CPC_GAP  = 3'b100
    } cpc_state_t;
endpackage

// >>> src/cpc_ctrl.sv
// Crank pickup conditioning control: registers, timing, blanking, deglitch and peak status
// Summary of operation
// [R01] Blanking codes 1000..1111 give windows of 25 to 46.9 percent of the last reference pulse in 1/32 steps.
// [R02] Bit 7 of the misc register enables automatic threshold choice, whose behaviour is left open.
// [R03] The positive peak of each pulse is reported as a 4-bit log code in status bits 7 to 4.
// [R04] The peak field holds the last detected peak and clears only by reset or the reset command.
// [R05] The host reads the peak code after each zero crossing to choose later settings.
// [R06] When enabled, short transitions on both edges shorter than about 1% of the last period are rejected.
// [R07] Deglitching is active only while misc bit 3 is one; it resets to zero.
// [R08] The high/low reference bit selects low pulse timing when one, high pulse timing when zero.
// [R09] The disable bit switches the pickup conditioning off when one; it resets to zero.
// [R10] Two clamp status bits read one while the high or low half of the waveform is clamped.
// [R11] The host may switch to running settings once a clamp bit is seen.
// [R12] A zero cranking register selects the running codes, otherwise the cranking codes apply.
//
// Design decisions made here: the address map and strobed register access.
module cpc_ctrl
(
    input  wire logic             i_ref_clk,
    input  wire logic             i_rst_n,
    input  wire logic [3:0]       i_addr,
    input  wire logic [7:0]       i_wdata,
    input  wire logic             i_wr,
    input  wire logic             i_rd,
    output logic [7:0]            o_rdata,
    input  wire logic             i_reluctance_pickup_cmp,
    input  wire logic             i_peak_valid,
    input  wire logic [3:0]       i_peak_code,
    input  wire logic             i_clamp_hi,
    input  wire logic             i_clamp_lo,
    output cpc_pkg::cpc_sel_t     o_sel,
    output logic                  o_auto_thresh,
    output logic                  o_pickup_enable,
    output logic                  o_pulse_out
);
    import cpc_pkg::*;
    `include "cpc_cfg.svh"

    logic [7:0]  run_cfg_r, run_cfg_nxt;
    logic [7:0]  crank_r, crank_nxt;
    logic [7:0]  misc_r, misc_nxt;
    logic [3:0]  peak_r, peak_nxt;
    logic [7:0]  rdata_r, rdata_nxt;
    logic        soft_rst;
    cpc_sel_t    sel;

    assign soft_rst = i_wr && (i_addr == `CPC_ADDR_CMD) && i_wdata[`CPC_CMD_RESET_BIT];

    always_comb
    begin
        // Running settings apply once the cranking register is cleared
        sel = (crank_r == 8'h00) ? cpc_sel_t'(run_cfg_r) : cpc_sel_t'(crank_r); // [R12]
    end

    // Register file and peak status
    always_comb
    begin
        run_cfg_nxt = run_cfg_r;
        crank_nxt   = crank_r;
        misc_nxt    = misc_r;
        peak_nxt    = peak_r;
        rdata_nxt   = 8'h00;
        if (i_wr)
        begin
            case (i_addr)
                `CPC_ADDR_RUN_CFG:    run_cfg_nxt = i_wdata;
                `CPC_ADDR_CRANK_CTRL: crank_nxt = i_wdata; // [R12]
                `CPC_ADDR_MISC_CFG:   misc_nxt = i_wdata; // [R02] [R07] [R08] [R09]
                default:              ;
            endcase
        end
        if (i_peak_valid && !misc_r[`CPC_MISC_DISABLE_BIT])
        begin
            peak_nxt = i_peak_code; // [R03] [R04]
        end
        if (i_rd)
        begin
            case (i_addr)
                `CPC_ADDR_RUN_CFG:    rdata_nxt = run_cfg_r;
                `CPC_ADDR_CRANK_CTRL: rdata_nxt = crank_r;
                `CPC_ADDR_MISC_CFG:   rdata_nxt = misc_r;
                `CPC_ADDR_STATUS:     rdata_nxt = {peak_r, 2'b00, i_clamp_hi, i_clamp_lo}; // [R03] [R10]
                default:              rdata_nxt = 8'h00;
            endcase
        end
        if (soft_rst)
        begin
            run_cfg_nxt = `CPC_RST_RUN_CFG;
            crank_nxt   = `CPC_RST_CRANK_CTRL;
            misc_nxt    = `CPC_RST_MISC_CFG;
            peak_nxt    = `CPC_PEAK_RST; // [R04]
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            run_cfg_r <= `CPC_RST_RUN_CFG;
            crank_r   <= `CPC_RST_CRANK_CTRL;
            misc_r    <= `CPC_RST_MISC_CFG;
            peak_r    <= `CPC_PEAK_RST;
            rdata_r   <= 8'h00;
        end
        else
        begin
            run_cfg_r <= run_cfg_nxt;
            crank_r   <= crank_nxt;
            misc_r    <= misc_nxt;
            peak_r    <= peak_nxt;
            rdata_r   <= rdata_nxt;
        end
    end

    // Pulse timing: deglitch, reference pulse width, blanking
    logic        en, hilo, degl_en;
    logic        filt_r, filt_nxt;
    logic        out_r, out_nxt;
    logic [15:0] glitch_r, glitch_nxt;
    logic [15:0] refw_r, refw_nxt;
    logic [15:0] per_r, per_nxt;
    logic [15:0] lastref_r, lastref_nxt;
    logic [15:0] lastper_r, lastper_nxt;
    logic [15:0] blank_r, blank_nxt;
    logic [15:0] degl_lim;
    logic [15:0] blank_lim;
    logic        ref_level;
    cpc_state_t  st_r, st_nxt;

    assign en        = !misc_r[`CPC_MISC_DISABLE_BIT]; // [R09]
    assign hilo      = misc_r[`CPC_MISC_HILO_BIT];
    assign degl_en   = misc_r[`CPC_MISC_DEGL_BIT]; // [R07]
    assign ref_level = !hilo; // [R08]
    // Period over 128 approximates 1%; shift keeps the divider out of the path
    assign degl_lim  = lastper_r >> `CPC_DEGL_SHIFT; // [R06]
    // Window is code/32 of the last reference pulse: 8/32 = 25 percent up to 15/32 = 46.9 percent
    assign blank_lim = 16'((32'(lastref_r) * 32'(sel.blank)) >> `CPC_BLANK_SHIFT); // [R01]

    always_comb
    begin
        filt_nxt    = filt_r;
        glitch_nxt  = 16'h0000;
        refw_nxt    = refw_r;
        per_nxt     = (per_r == 16'hffff) ? per_r : per_r + 16'h0001;
        lastref_nxt = lastref_r;
        lastper_nxt = lastper_r;
        blank_nxt   = (blank_r == 16'h0000) ? blank_r : blank_r - 16'h0001;
        out_nxt     = out_r;
        st_nxt      = st_r;
        if (!en)
        begin
            filt_nxt = 1'b0;
            out_nxt  = 1'b0;
            st_nxt   = CPC_IDLE;
        end
        else
        begin
            if (i_reluctance_pickup_cmp != filt_r)
            begin
                // Both edges must persist past the window before they count
                if (!degl_en || glitch_r >= degl_lim) // [R06] [R07]
                    filt_nxt = i_reluctance_pickup_cmp;
                else
                    glitch_nxt = glitch_r + 16'h0001;
            end
            case (st_r)
                CPC_IDLE:
                begin
                    if (filt_nxt == ref_level && filt_r != ref_level)
                    begin
                        st_nxt   = CPC_REF;
                        refw_nxt = 16'h0000;
                        per_nxt  = 16'h0000;
                    end
                end
                CPC_REF:
                begin
                    refw_nxt = (refw_r == 16'hffff) ? refw_r : refw_r + 16'h0001;
                    if (filt_nxt != ref_level)
                    begin
                        lastref_nxt = refw_r; // [R08]
                        st_nxt      = CPC_GAP;
                    end
                end
                CPC_GAP:
                begin
                    if (filt_nxt == ref_level && blank_r == 16'h0000)
                    begin
                        lastper_nxt = per_r;
                        per_nxt     = 16'h0000;
                        refw_nxt    = 16'h0000;
                        st_nxt      = CPC_REF;
                    end
                end
                default: st_nxt = CPC_IDLE;
            endcase
            if (filt_nxt != out_r && blank_r == 16'h0000)
            begin
                out_nxt   = filt_nxt;
                blank_nxt = blank_lim; // [R01]
            end
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            filt_r    <= 1'b0;
            glitch_r  <= 16'h0000;
            refw_r    <= 16'h0000;
            per_r     <= 16'h0000;
            lastref_r <= 16'h0000;
            lastper_r <= 16'h0000;
            blank_r   <= 16'h0000;
            out_r     <= 1'b0;
            st_r      <= CPC_IDLE;
        end
        else
        begin
            filt_r    <= filt_nxt;
            glitch_r  <= glitch_nxt;
            refw_r    <= refw_nxt;
            per_r     <= per_nxt;
            lastref_r <= lastref_nxt;
            lastper_r <= lastper_nxt;
            blank_r   <= blank_nxt;
            out_r     <= out_nxt;
            st_r      <= st_nxt;
        end
    end

    assign o_rdata         = rdata_r;
    assign o_sel           = sel;
    assign o_auto_thresh   = misc_r[`CPC_MISC_AUTO_BIT]; // [R02]
    assign o_pickup_enable = en;
    assign o_pulse_out     = out_r;

    chk_crank_select: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        (crank_r != 8'h00) |-> (o_sel == cpc_sel_t'(crank_r))) else $error("cranking codes not used"); // [R12]
    chk_run_select: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        (crank_r == 8'h00) |-> (o_sel == cpc_sel_t'(run_cfg_r))) else $error("running codes not used"); // [R12]
    chk_peak_hold: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        (!$past(i_peak_valid) && !$past(soft_rst)) |-> $stable(peak_r)) else $error("peak changed without event"); // [R04]
    chk_peak_load: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        (i_peak_valid && en && !soft_rst) |=> (peak_r == $past(i_peak_code))) else $error("peak not captured"); // [R03]
    chk_soft_reset: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        soft_rst |=> (peak_r == 4'h0 && misc_r == 8'h00 && crank_r == 8'h00)) else $error("reset command failed"); // [R04]
    chk_status_read: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        (i_rd && i_addr == `CPC_ADDR_STATUS) |=> (o_rdata[7:4] == $past(peak_r)
        && o_rdata[1:0] == $past({i_clamp_hi, i_clamp_lo}))) else $error("status read wrong"); // [R03] [R10]
    chk_disable_off: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        misc_r[`CPC_MISC_DISABLE_BIT] |=> !o_pulse_out) else $error("output active while disabled"); // [R09]
    chk_no_degl: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        (en && !degl_en && i_reluctance_pickup_cmp != filt_r) |=> (filt_r == $past(i_reluctance_pickup_cmp)))
        else $error("edge delayed without deglitch"); // [R07]
    chk_blank_load: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        (en && out_nxt != out_r) |=> (blank_r == $past(blank_lim))) else $error("blank window not loaded"); // [R01]
    chk_auto_bit: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        (i_wr && i_addr == `CPC_ADDR_MISC_CFG && !soft_rst) |=> (o_auto_thresh == $past(i_wdata[7])))
        else $error("auto bit not stored"); // [R02]
    cov_crank_to_run: cover property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        (crank_r != 8'h00) ##1 (crank_r == 8'h00));
    cov_degl_reject: cover property (@(posedge i_ref_clk) disable iff (!i_rst_n) (glitch_nxt != 16'h0000));
    cov_full_period: cover property (@(posedge i_ref_clk) disable iff (!i_rst_n) (st_r == CPC_GAP) ##1 (st_r == CPC_REF));
    cov_peak_seen: cover property (@(posedge i_ref_clk) disable iff (!i_rst_n) i_peak_valid && en);

    // Deglitch filter checks: a short edge must neither pass early nor stall the counter
    chk_degl_hold: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        (en && degl_en && i_reluctance_pickup_cmp != filt_r && glitch_r < degl_lim) |=> (filt_r == $past(filt_r)))
        else $error("short edge passed the filter"); // [R06]
    chk_degl_count: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        (en && degl_en && i_reluctance_pickup_cmp != filt_r && glitch_r < degl_lim)
        |=> (glitch_r == $past(glitch_r) + 16'h0001)) else $error("glitch counter stalled"); // [R06]
    chk_degl_accept: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        (en && degl_en && i_reluctance_pickup_cmp != filt_r && glitch_r >= degl_lim)
        |=> (filt_r == $past(i_reluctance_pickup_cmp))) else $error("long edge not accepted"); // [R06]
    // Blanking must freeze the output and count down by one each cycle
    chk_blank_hold: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        (en && blank_r != 16'h0000) |=> (o_pulse_out == $past(o_pulse_out)))
        else $error("output moved inside blank window"); // [R01]
    chk_blank_count: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        (en && blank_r != 16'h0000) |=> (blank_r == $past(blank_r) - 16'h0001))
        else $error("blank window not counting"); // [R01]
    // Reference pulse follows the high/low bit, so its width feeds the window
    chk_ref_start: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        (en && st_r == CPC_IDLE && filt_r != ref_level && filt_nxt == ref_level) |=> (st_r == CPC_REF))
        else $error("reference pulse not started"); // [R08]
    chk_ref_capture: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        (en && st_r == CPC_REF && filt_nxt != ref_level) |=> (lastref_r == $past(refw_r)))
        else $error("reference width not captured"); // [R08]
    // Disabled front end parks the state machine and filter and freezes the peak status
    chk_disable_idle: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        !en |=> (st_r == CPC_IDLE && !filt_r)) else $error("timing active while disabled"); // [R09]
    chk_peak_disabled: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        (!en && !soft_rst) |=> $stable(peak_r)) else $error("peak captured while disabled"); // [R09]
    // Read data stands only in the cycle after a read strobe
    chk_read_idle: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        !i_rd |=> (o_rdata == 8'h00)) else $error("read data outside read cycle");
    cov_low_ref: cover property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        (hilo && st_r == CPC_REF) ##1 (st_r == CPC_GAP));
endmodule

// >>> tb/cpc_pickup_model.sv
// Behavioural pickup coil and front end: comparator, peak digitiser and clamp flags
module cpc_pickup_model
(
    input  wire logic       i_ref_clk,
    input  wire logic       i_rst_n,
    input  wire logic       i_go,
    input  wire logic [7:0] i_len,
    input  wire logic [3:0] i_code,
    input  wire logic       i_spike,
    input  wire logic [3:0] i_spike_len,
    input  wire logic       i_clamp_hi_req,
    input  wire logic       i_clamp_lo_req,
    output logic            o_cmp,
    output logic            o_peak_valid,
    output logic [3:0]      o_peak_code,
    output logic            o_clamp_hi,
    output logic            o_clamp_lo
);
    timeunit 1ns;
    timeprecision 100ps;
    logic       hi_r;
    logic [7:0] cnt_r;
    logic [3:0] sp_r;
    logic [3:0] last_r;
    // A started high half always finishes, so stopping never cuts a pulse short
    always_ff @(posedge i_ref_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            hi_r         <= 1'b0;
            cnt_r        <= 8'h00;
            sp_r         <= 4'h0;
            last_r       <= 4'h0;
            o_peak_valid <= 1'b0;
        end
        else
        begin
            o_peak_valid <= 1'b0;
            if (i_spike && !hi_r)
                sp_r <= i_spike_len;
            else if (sp_r != 4'h0)
                sp_r <= sp_r - 4'h1;
            if (i_go || hi_r)
            begin
                if (cnt_r == i_len - 8'h01)
                begin
                    cnt_r <= 8'h00;
                    hi_r  <= !hi_r;
                    if (hi_r)
                    begin
                        o_peak_valid <= 1'b1;
                        last_r       <= i_code;
                    end
                end
                else
                    cnt_r <= cnt_r + 8'h01;
            end
        end
    end
    assign o_cmp       = hi_r | (sp_r != 4'h0);
    // Code is garbage outside its valid pulse
    assign o_peak_code = o_peak_valid ? last_r : ~last_r;
    assign o_clamp_hi  = i_clamp_hi_req;
    assign o_clamp_lo  = i_clamp_lo_req;
endmodule

// >>> tb/crank_pickup_conditioning_ctrl_bench.sv
// Self-checking bench of the pickup conditioning control
`include "cpc_cfg.svh"
`define BENCH_CHK(got, exp) begin total_checks++; if ((got) !== (exp)) begin failures++; \
    $display("unexpected at %0t: got %h exp %h", $time, (got), (exp)); end end
module crank_pickup_conditioning_ctrl_bench;
    timeunit 1ns;
    timeprecision 100ps;
    import cpc_pkg::*;
    logic       i_ref_clk = 1'b0, i_rst_n = 1'b0, i_wr = 1'b0, i_rd = 1'b0;
    logic       go = 1'b0, spike = 1'b0, chi = 1'b0, clo = 1'b0, seen;
    logic [3:0] i_addr = 4'h0, code = 4'h0, splen = 4'h0, pc;
    logic [7:0] i_wdata = 8'h00, len = 8'h40, rd_v, o_rdata;
    logic       cmp, pv, c_hi, c_lo, o_auto_thresh, o_pickup_enable, o_pulse_out;
    cpc_sel_t   o_sel;
    int         failures = 0, total_checks = 0;
    always #25 i_ref_clk = ~i_ref_clk;
    cpc_ctrl i_dut (.i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .i_addr(i_addr), .i_wdata(i_wdata),
        .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_reluctance_pickup_cmp(cmp), .i_peak_valid(pv),
        .i_peak_code(pc), .i_clamp_hi(c_hi), .i_clamp_lo(c_lo), .o_sel(o_sel),
        .o_auto_thresh(o_auto_thresh), .o_pickup_enable(o_pickup_enable), .o_pulse_out(o_pulse_out));
    cpc_pickup_model i_coil (.i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .i_go(go), .i_len(len), .i_code(code),
        .i_spike(spike), .i_spike_len(splen), .i_clamp_hi_req(chi), .i_clamp_lo_req(clo), .o_cmp(cmp),
        .o_peak_valid(pv), .o_peak_code(pc), .o_clamp_hi(c_hi), .o_clamp_lo(c_lo));
    task automatic cyc(input int n);
        repeat (n) @(posedge i_ref_clk);
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge i_ref_clk);
        i_wr    <= 1'b1;
        i_addr  <= a;
        i_wdata <= d;
        @(posedge i_ref_clk);
        i_wr <= 1'b0;
        #1;
    endtask
    task automatic rd(input logic [3:0] a);
        @(posedge i_ref_clk);
        i_rd   <= 1'b1;
        i_addr <= a;
        @(posedge i_ref_clk);
        i_rd <= 1'b0;
        #1 rd_v = o_rdata;
    endtask
    // Stops the wheel at the end of a high half so the next low half is quiet
    task automatic stop_hi();
        repeat (300) @(posedge i_ref_clk) if (cmp === 1'b1) break;
        go <= 1'b0;
        repeat (300) @(posedge i_ref_clk) if (cmp === 1'b0) break;
    endtask
    task automatic spike_seen(input logic [3:0] n);
        @(posedge i_ref_clk);
        spike <= 1'b1;
        splen <= n;
        @(posedge i_ref_clk);
        spike <= 1'b0;
        seen = 1'b0;
        repeat (10) @(posedge i_ref_clk) #1 seen |= o_pulse_out;
    endtask
    task automatic t_reset();
        rd(`CPC_ADDR_RUN_CFG);
        `BENCH_CHK(rd_v, `CPC_RST_RUN_CFG)
        rd(`CPC_ADDR_CRANK_CTRL);
        `BENCH_CHK(rd_v, `CPC_RST_CRANK_CTRL)
        rd(`CPC_ADDR_MISC_CFG);
        `BENCH_CHK(rd_v, `CPC_RST_MISC_CFG)
        rd(`CPC_ADDR_STATUS);
        `BENCH_CHK(rd_v[7:4], `CPC_PEAK_RST)
        `BENCH_CHK(o_sel, 8'h50)
        `BENCH_CHK({o_pickup_enable, o_auto_thresh}, 2'b10)
        rd(4'hf);
        `BENCH_CHK(rd_v, 8'h00)
    endtask
    task automatic t_misc();
        wr(`CPC_ADDR_MISC_CFG, 8'h80);
        `BENCH_CHK(o_auto_thresh, 1'b1)
        wr(`CPC_ADDR_MISC_CFG, 8'h02);
        `BENCH_CHK({o_pickup_enable, o_auto_thresh}, 2'b00)
        wr(`CPC_ADDR_MISC_CFG, 8'h04);
        rd(`CPC_ADDR_MISC_CFG);
        `BENCH_CHK(rd_v, 8'h04)
        wr(`CPC_ADDR_MISC_CFG, 8'h00);
    endtask
    task automatic t_peak();
        code <= 4'hb;
        go   <= 1'b1;
        stop_hi();
        cyc(4);
        rd(`CPC_ADDR_STATUS);
        `BENCH_CHK(rd_v[7:4], 4'hb)
        wr(`CPC_ADDR_STATUS, 8'hff);
        chi <= 1'b1;
        rd(`CPC_ADDR_STATUS);
        `BENCH_CHK(rd_v, 8'hb2)
        chi <= 1'b0;
        clo <= 1'b1;
        rd(`CPC_ADDR_STATUS);
        `BENCH_CHK(rd_v[1:0], 2'b01)
        clo <= 1'b0;
        wr(`CPC_ADDR_CRANK_CTRL, 8'h9c);
        `BENCH_CHK(o_sel, 8'h9c)
        wr(`CPC_ADDR_CRANK_CTRL, 8'h00);
        `BENCH_CHK(o_sel, 8'h50)
        wr(`CPC_ADDR_MISC_CFG, 8'h02);
        code <= 4'h3;
        go   <= 1'b1;
        stop_hi();
        rd(`CPC_ADDR_STATUS);
        `BENCH_CHK(rd_v[7:4], 4'hb)
        wr(`CPC_ADDR_RUN_CFG, 8'h7a);
        wr(`CPC_ADDR_CMD, 8'h01);
        rd(`CPC_ADDR_STATUS);
        `BENCH_CHK(rd_v[7:4], `CPC_PEAK_RST)
        rd(`CPC_ADDR_RUN_CFG);
        `BENCH_CHK({rd_v, o_pickup_enable}, {`CPC_RST_RUN_CFG, 1'b1})
    endtask
    task automatic t_blank();
        wr(`CPC_ADDR_RUN_CFG, 8'h58);
        go <= 1'b1;
        cyc(300);
        stop_hi();
        spike_seen(4'h4);
        `BENCH_CHK(seen, 1'b0)
        wr(`CPC_ADDR_RUN_CFG, 8'h50);
        go <= 1'b1;
        stop_hi();
        spike_seen(4'h4);
        `BENCH_CHK(seen, 1'b1)
    endtask
    task automatic t_deglitch();
        wr(`CPC_ADDR_MISC_CFG, 8'h08);
        len <= 8'h80;
        go  <= 1'b1;
        cyc(520);
        stop_hi();
        cyc(20);
        spike_seen(4'h1);
        `BENCH_CHK(seen, 1'b0)
        spike_seen(4'h8);
        `BENCH_CHK(seen, 1'b1)
        wr(`CPC_ADDR_MISC_CFG, 8'h00);
        spike_seen(4'h1);
        `BENCH_CHK(seen, 1'b1)
    endtask
    task automatic complete_run();
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    initial
    begin
        cyc(2);
        i_rst_n <= 1'b1;
        t_reset();
        t_misc();
        t_peak();
        t_blank();
        t_deglitch();
        complete_run();
    end
    // Whole sequence needs about 1700 cycles
    initial
    begin
        cyc(20000);
        failures++;
        complete_run();
    end
endmodule
